// >>> verilog/pwm_pkg.sv
// Package with register map, field positions and reset values of the PWM channel.
package pwm_pkg;
    localparam logic [11:0] PWM_OFF_TIMER_COUNT = 12'h000;
    localparam logic [11:0] PWM_OFF_PERIOD      = 12'h004;
    localparam logic [11:0] PWM_OFF_TIMER_CTRL  = 12'h008;
    localparam logic [11:0] PWM_OFF_DUTY_STAGE  = 12'h00C;
    localparam logic [11:0] PWM_OFF_DUTY_ACTIVE = 12'h010;
    localparam logic [11:0] PWM_OFF_MODULE_CTRL = 12'h014;
    localparam logic [11:0] PWM_OFF_PIN_DIR     = 12'h018;
    localparam int PWM_TC_RUN_BIT    = 2;
    localparam int PWM_TC_PS_LSB     = 0;
    localparam int PWM_TC_POST_LSB   = 3;
    localparam int PWM_MC_DUTY_LSB   = 4;
    localparam int PWM_MC_MODE_LSB   = 0;
    localparam logic [1:0] PWM_MODE_PWM  = 2'h3;
    localparam logic [7:0] PWM_RST_BYTE  = 8'h00;
    localparam logic [7:0] PWM_RST_PERIOD = 8'hFF;
    localparam logic [0:0] PWM_RST_DIR   = 1'h1;
    localparam logic [3:0] PWM_PS_CNT_1  = 4'h0;
    localparam logic [3:0] PWM_PS_CNT_4  = 4'h3;
    localparam logic [3:0] PWM_PS_CNT_16 = 4'hF;
    localparam logic [1:0] PWM_PHASE_LAST = 2'h3;
endpackage

// >>> verilog/pwm_channel.sv
// Single PWM output channel with period timer, prescaler and double-buffered duty, on APB.
module pwm_channel
    import pwm_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             pwm_pin_out,
    output logic             pwm_pin_oe_out
);
    logic [7:0] timer_count_ff;
    logic [7:0] period_ff;
    logic [6:0] timer_ctrl_ff;
    logic [7:0] duty_stage_ff;
    logic [7:0] duty_active_ff;
    logic [1:0] duty_low_latch_ff;
    logic [5:0] module_ctrl_ff;
    logic       pin_dir_ff;
    logic       out_latch_ff;
    logic [1:0] phase_ff;
    logic [3:0] prescale_ff;
    logic       wr_en;
    logic       pwm_mode;
    logic [3:0] ps_last;
    logic       tick;
    logic       period_end;
    logic [9:0] duty_active;
    logic [9:0] time_ext;
    logic [1:0] low_bits;
    logic [1:0] nxt_phase;
    logic [3:0] nxt_prescale;
    logic [7:0] nxt_timer_count;
    logic [7:0] nxt_rdata;
    logic [7:0] prdata_ff;
    logic       wr_count;
    logic       wr_period;
    logic       wr_tctrl;
    logic       wr_stage;
    logic       wr_active;
    logic       wr_mctrl;
    logic       wr_dir;

    assign wr_en = psel_in && penable_in && pwrite_in;
    assign pready_out = 1'b1;
    assign pwm_mode = (module_ctrl_ff[PWM_MC_MODE_LSB+3 -: 2] == PWM_MODE_PWM);

    // One decoded strobe per register keeps each register process to a single enable.
    always_comb
    begin
        wr_count  = 1'b0;
        wr_period = 1'b0;
        wr_tctrl  = 1'b0;
        wr_stage  = 1'b0;
        wr_active = 1'b0;
        wr_mctrl  = 1'b0;
        wr_dir    = 1'b0;
        if (paddr_in == PWM_OFF_TIMER_COUNT)
        begin
            wr_count = wr_en;
        end
        else if (paddr_in == PWM_OFF_PERIOD)
        begin
            wr_period = wr_en;
        end
        else if (paddr_in == PWM_OFF_TIMER_CTRL)
        begin
            wr_tctrl = wr_en;
        end
        else if (paddr_in == PWM_OFF_DUTY_STAGE)
        begin
            wr_stage = wr_en;
        end
        else if (paddr_in == PWM_OFF_DUTY_ACTIVE)
        begin
            wr_active = wr_en;
        end
        else if (paddr_in == PWM_OFF_MODULE_CTRL)
        begin
            wr_mctrl = wr_en;
        end
        else if (paddr_in == PWM_OFF_PIN_DIR)
        begin
            wr_dir = wr_en;
        end
    end

    // Prescale select: 00 is 1:1, 01 is 1:4, 1x is 1:16.
    always_comb
    begin
        if (timer_ctrl_ff[PWM_TC_PS_LSB+1])
        begin
            ps_last = PWM_PS_CNT_16;
        end
        else if (timer_ctrl_ff[PWM_TC_PS_LSB])
        begin
            ps_last = PWM_PS_CNT_4;
        end
        else
        begin
            ps_last = PWM_PS_CNT_1;
        end
    end

    // The postscaler bits are stored but deliberately feed nothing here.
    assign tick = timer_ctrl_ff[PWM_TC_RUN_BIT] && (phase_ff == PWM_PHASE_LAST)
                  && (prescale_ff == ps_last);
    assign period_end = tick && (timer_count_ff == period_ff);
    assign duty_active = {duty_active_ff, duty_low_latch_ff};

    // Low comparison bits: phase counter at 1:1, prescaler bits 1:0 at 1:4, top two prescaler bits at 1:16.
    // The compare looks at the next counter values, so the pin falls on the very
    // cycle at which the count reaches the duty value instead of one clock later.
    always_comb
    begin
        if (ps_last == PWM_PS_CNT_1)
        begin
            low_bits = nxt_phase;
        end
        else if (ps_last == PWM_PS_CNT_4)
        begin
            low_bits = nxt_prescale[1:0];
        end
        else
        begin
            low_bits = nxt_prescale[3:2];
        end
    end
    assign time_ext = {nxt_timer_count, low_bits};

    // Phase counter runs free, standing in for the four oscillator phases.
    assign nxt_phase = phase_ff + 2'h1;

    // A timer control write restarts the prescaler so that a new ratio starts cleanly.
    always_comb
    begin
        if (wr_tctrl)
        begin
            nxt_prescale = 4'h0;
        end
        else if (timer_ctrl_ff[PWM_TC_RUN_BIT] && phase_ff == PWM_PHASE_LAST)
        begin
            nxt_prescale = (prescale_ff == ps_last) ? 4'h0 : prescale_ff + 4'h1;
        end
        else
        begin
            nxt_prescale = prescale_ff;
        end
    end

    always_comb
    begin
        if (wr_count)
        begin
            nxt_timer_count = pwdata_in[7:0];
        end
        else if (period_end)
        begin
            nxt_timer_count = 8'h00;
        end
        else if (tick)
        begin
            nxt_timer_count = timer_count_ff + 8'h01;
        end
        else
        begin
            nxt_timer_count = timer_count_ff;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            phase_ff <= 2'h0;
        end
        else
        begin
            phase_ff <= nxt_phase;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prescale_ff <= 4'h0;
        end
        else
        begin
            prescale_ff <= nxt_prescale;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            timer_count_ff <= PWM_RST_BYTE;
        end
        else
        begin
            timer_count_ff <= nxt_timer_count;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            period_ff      <= PWM_RST_PERIOD;
            timer_ctrl_ff  <= 7'h00;
            duty_stage_ff  <= PWM_RST_BYTE;
            module_ctrl_ff <= 6'h00;
            pin_dir_ff     <= PWM_RST_DIR;
        end
        else if (wr_en)
        begin
            if (wr_period)
            begin
                period_ff <= pwdata_in[7:0];
            end
            else if (wr_tctrl)
            begin
                timer_ctrl_ff <= pwdata_in[6:0];
            end
            else if (wr_stage)
            begin
                duty_stage_ff <= pwdata_in[7:0];
            end
            else if (wr_mctrl)
            begin
                module_ctrl_ff <= pwdata_in[5:0];
            end
            else if (wr_dir)
            begin
                pin_dir_ff <= pwdata_in[0];
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            duty_active_ff    <= PWM_RST_BYTE;
            duty_low_latch_ff <= 2'h0;
        end
        else if (pwm_mode && period_end)
        begin
            duty_active_ff    <= duty_stage_ff;
            duty_low_latch_ff <= module_ctrl_ff[PWM_MC_DUTY_LSB+1 -: 2];
        end
        else if (!pwm_mode && wr_active)
        begin
            duty_active_ff <= pwdata_in[7:0];
        end
    end

    // Set on period end wins over the duty match; a zero duty never sets the pin.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            out_latch_ff <= 1'b0;
        end
        else if (wr_mctrl && pwdata_in[5:0] == 6'h00)
        begin
            out_latch_ff <= 1'b0;
        end
        else if (!pwm_mode)
        begin
            out_latch_ff <= out_latch_ff;
        end
        else if (period_end)
        begin
            out_latch_ff <= ({duty_stage_ff, module_ctrl_ff[PWM_MC_DUTY_LSB+1 -: 2]} != 10'h000);
        end
        else if (duty_active == time_ext)
        begin
            out_latch_ff <= 1'b0;
        end
    end

    assign pwm_pin_out    = out_latch_ff;
    assign pwm_pin_oe_out = !pin_dir_ff;

    // Read data is captured in the setup cycle and stands through the access phase.
    always_comb
    begin
        pslverr_out = 1'b0;
        nxt_rdata   = 8'h00;
        if (paddr_in == PWM_OFF_TIMER_COUNT)
        begin
            nxt_rdata = timer_count_ff;
        end
        else if (paddr_in == PWM_OFF_PERIOD)
        begin
            nxt_rdata = period_ff;
        end
        else if (paddr_in == PWM_OFF_TIMER_CTRL)
        begin
            nxt_rdata = {1'b0, timer_ctrl_ff};
        end
        else if (paddr_in == PWM_OFF_DUTY_STAGE)
        begin
            nxt_rdata = duty_stage_ff;
        end
        else if (paddr_in == PWM_OFF_DUTY_ACTIVE)
        begin
            nxt_rdata = duty_active_ff;
        end
        else if (paddr_in == PWM_OFF_MODULE_CTRL)
        begin
            nxt_rdata = {2'h0, module_ctrl_ff};
        end
        else if (paddr_in == PWM_OFF_PIN_DIR)
        begin
            nxt_rdata = {7'h00, pin_dir_ff};
        end
        else
        begin
            pslverr_out = psel_in && penable_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prdata_ff <= 8'h00;
        end
        else if (psel_in && !penable_in)
        begin
            prdata_ff <= nxt_rdata;
        end
    end

    assign prdata_out = {24'h00_0000, prdata_ff};
endmodule

// >>> verif/pwm_load_model.sv
// Load model on the PWM pin that measures pulse and period lengths.
module pwm_load_model (
    input  wire logic clk_sys_in,
    input  wire logic pin_in,
    input  wire logic oe_in,
    output int        high_len_out,
    output int        period_len_out,
    output int        high_tot_out,
    output int        low_tot_out
);
    timeunit 1ns;
    timeprecision 1ps;
    bit last_ff;
    int hcnt;
    int pcnt;
    // Lengths are taken between detected edges, so a partial first period is simply overwritten.
    always @(posedge clk_sys_in)
    begin
        last_ff <= pin_in;
        pcnt <= (pin_in && !last_ff) ? 1 : pcnt + 1;
        hcnt <= (pin_in && !last_ff) ? 1 : hcnt + int'(pin_in);
        if (pin_in && !last_ff)
            period_len_out <= pcnt;
        if (!pin_in && last_ff)
            high_len_out <= hcnt;
        high_tot_out <= high_tot_out + int'(oe_in && pin_in);
        low_tot_out <= low_tot_out + int'(oe_in && !pin_in);
    end
endmodule

// >>> verif/pwm_channel_assertions.sv
// Concurrent checks on the bus and pin ports of the PWM channel.
module pwm_channel_assertions
    import pwm_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        pwm_pin_out,
    input wire logic        pwm_pin_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       acc;
    logic [7:0] wbyte;
    assign acc = psel_in && penable_in;
    assign wbyte = pwdata_in[7:0];
    default clocking dcb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence wr_stage;
        acc && pwrite_in && paddr_in == PWM_OFF_DUTY_STAGE;
    endsequence
    sequence rd_stage;
        psel_in && !penable_in && !pwrite_in && paddr_in == PWM_OFF_DUTY_STAGE;
    endsequence
    chk_ready_high: assert property (pready_out)
        else $error("ready low");
    chk_err_decode: assert property (acc && paddr_in[1:0] == 2'h0 |-> pslverr_out == (paddr_in > PWM_OFF_PIN_DIR))
        else $error("error flag wrong");
    chk_err_idle: assert property (!acc |-> !pslverr_out)
        else $error("error flag outside access");
    chk_unmapped_zero: assert property (acc && !pwrite_in && paddr_in > PWM_OFF_PIN_DIR |-> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_upper: assert property (prdata_out[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_stage_readback: assert property (wr_stage ##2 rd_stage |=> prdata_out[7:0] == $past(wbyte, 3))
        else $error("staged duty lost");
    chk_ctrl_zero: assert property (acc && pwrite_in && paddr_in == PWM_OFF_MODULE_CTRL && wbyte == 8'h00 |=> !pwm_pin_out)
        else $error("pin not forced low");
    chk_dir_enable: assert property (acc && pwrite_in && paddr_in == PWM_OFF_PIN_DIR |=> pwm_pin_oe_out == !$past(wbyte[0]))
        else $error("pin enable wrong");
endmodule
bind pwm_channel pwm_channel_assertions i_chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .pwm_pin_out(pwm_pin_out), .pwm_pin_oe_out(pwm_pin_oe_out));

// >>> verif/pwm_channel_tb.sv
// Testbench that programs the PWM channel over APB and measures its pin.
module pwm_channel_tb import pwm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] PR = 8'h09;
    logic        clk_sys = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr, pin, oe, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int          n_errors, compares, hi_len, per_len, hi_tot, lo_tot, t, p;
    logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
    logic [7:0]  rv [7] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [7:0]  tcv [3] = '{8'h04, 8'h7D, 8'h2E};
    int          psv [3] = '{1, 4, 16};
    pwm_channel i_pwm_channel (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .pwm_pin_out(pin), .pwm_pin_oe_out(oe));
    pwm_load_model i_pwm_load_model (.clk_sys_in(clk_sys), .pin_in(pin), .oe_in(oe), .high_len_out(hi_len),
        .period_len_out(per_len), .high_tot_out(hi_tot), .low_tot_out(lo_tot));
    initial
        forever #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        chk(rdat, {24'h0, e});
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        {psel, penable, pwrite, rst_n} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (ra[i])
            rc(ra[i], rv[i]);
        rc(12'h01C, 8'h00);
        chk({31'h0, rerr}, 32'h1);
        $display("test reset done");
        apb(PWM_OFF_PERIOD, 1'b1, PR);
        apb(PWM_OFF_DUTY_STAGE, 1'b1, 8'h05);
        apb(PWM_OFF_PIN_DIR, 1'b1, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            p = (PR + 1) * 4 * psv[i];
            apb(PWM_OFF_TIMER_CTRL, 1'b1, tcv[i]);
            if (i == 0)
                apb(PWM_OFF_MODULE_CTRL, 1'b1, 8'h1C);
            repeat (3 * p) @(posedge clk_sys);
            chk(per_len, p);
            chk(hi_len, 21 * psv[i]);
        end
        $display("test timing done");
        apb(PWM_OFF_DUTY_STAGE, 1'b1, 8'h02);
        rc(PWM_OFF_DUTY_STAGE, 8'h02);
        apb(PWM_OFF_MODULE_CTRL, 1'b1, 8'h0C);
        repeat (3 * p) @(posedge clk_sys);
        chk(hi_len, 8 * 16);
        rc(PWM_OFF_DUTY_ACTIVE, 8'h02);
        apb(PWM_OFF_DUTY_ACTIVE, 1'b1, 8'hAA);
        rc(PWM_OFF_DUTY_ACTIVE, 8'h02);
        apb(PWM_OFF_DUTY_STAGE, 1'b1, 8'h00);
        apb(PWM_OFF_MODULE_CTRL, 1'b1, 8'h0C);
        repeat (2 * p) @(posedge clk_sys);
        t = hi_tot;
        repeat (p) @(posedge clk_sys);
        chk(hi_tot, t);
        apb(PWM_OFF_DUTY_STAGE, 1'b1, 8'hFF);
        apb(PWM_OFF_MODULE_CTRL, 1'b1, 8'h3C);
        repeat (2 * p) @(posedge clk_sys);
        t = lo_tot;
        repeat (p) @(posedge clk_sys);
        chk(lo_tot, t);
        apb(PWM_OFF_MODULE_CTRL, 1'b1, 8'h00);
        @(posedge clk_sys);
        chk({31'h0, pin}, 32'h0);
        $display("test duty done");
        close_out();
    end
    // The limit covers about three times the longest expected run.
    initial
    begin
        #200000;
        n_errors++;
        close_out();
    end
endmodule
